// [design/ast_trigger.sv]
// Summary of operation
// - With host origin, each host command starts one exposure when waiting.
// - Accepting a trigger leaves the waiting state at once.
// - The block returns to waiting by itself once the pipeline is ready.
// - A host command arriving while not waiting is dropped, never queued.
// - With a line origin, the selected input line is the start trigger.
// - Edge select picks the rising or falling edge; the other one is inert.
// - Every qualifying edge while waiting starts an acquisition.
// - Edges arriving while not waiting are ignored.
// - Internal triggering makes one trigger per begin, or runs until stop.
// - Internal rate is the maximum, or a slower programmed rate if limited.
// - A timed-mode trigger during exposure is ignored and flagged.
// - After reset line 1 is the trigger origin.
`timescale 1ns/1ps

module ast_trigger
    import ast_pkg::*;
(
    // Clock and reset
    input  wire logic             CLK_IN,
    input  wire logic             RST_IN,
    // Configuration
    input  wire logic             EXTERNAL_TRIGGER_ENABLE_IN,
    input  wire logic             CONTINUOUS_MODE_IN,
    input  wire logic             ORIGIN_WRITE_IN,
    input  wire logic [1:0]       TRIGGER_ORIGIN_SELECT_IN,
    input  wire logic             TRIGGER_EDGE_SELECT_IN,
    input  wire logic             EXPOSURE_CONTROL_SELECT_IN,
    input  wire logic             INTERNAL_RATE_LIMIT_ENABLE_IN,
    input  wire logic [CNT_W-1:0] EXPOSURE_DURATION_SETTING_IN,
    input  wire logic [CNT_W-1:0] MIN_FRAME_PERIOD_IN,
    input  wire logic [CNT_W-1:0] PROGRAMMED_PERIOD_IN,
    // Commands, one-cycle pulses
    input  wire logic             BEGIN_ACQUISITION_COMMAND_IN,
    input  wire logic             END_ACQUISITION_COMMAND_IN,
    input  wire logic             HOST_TRIGGER_COMMAND_IN,
    // Pins and pipeline
    input  wire logic [LINE_COUNT-1:0] EXTERNAL_START_TRIGGER_INPUT_IN,
    input  wire logic             PIPELINE_READY_IN,
    // Status
    output logic [1:0]            TRIGGER_ORIGIN_OUT,
    output logic                  WAITING_OUT,
    output logic                  EXPOSING_OUT,
    output logic                  FRAME_START_OUT,
    output logic                  OVERTRIGGER_OUT,
    output logic                  IGNORED_TRIGGER_OUT
);

    ast_state_t       state_ff;
    ast_state_t       nxt_state;
    logic             acq_active_ff;
    logic [1:0]       origin_ff;
    logic [CNT_W-1:0] expo_cnt_ff;
    logic [CNT_W-1:0] rate_cnt_ff;
    logic [LINE_COUNT-1:0] line_pulse;
    logic             ext_pulse;
    logic             host_pulse;
    logic             int_pulse;
    logic             trig;
    logic             waiting;
    logic [CNT_W-1:0] period;

    // Every line keeps its own detector so that switching the origin never
    // shows a stale edge left over from the previously selected line.
    genvar g;
    generate
        for (g = 0; g < LINE_COUNT; g = g + 1) begin : g_line
            ast_edge_detect u_edge (
                .clk_in     (CLK_IN),
                .rst_in     (RST_IN),
                .level_in   (EXTERNAL_START_TRIGGER_INPUT_IN[g]),
                .falling_in (TRIGGER_EDGE_SELECT_IN),
                .pulse_out  (line_pulse[g])
            );
        end
    endgenerate

    // The origin is a stored setting; the select bus only matters while the
    // write strobe is high, so the host may leave it at any value.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            origin_ff <= ORIGIN_RESET;
        end else if (ORIGIN_WRITE_IN) begin
            origin_ff <= TRIGGER_ORIGIN_SELECT_IN;
        end
    end

    // Only the selected origin may reach the trigger path.
    always_comb begin
        ext_pulse  = 1'b0;
        host_pulse = 1'b0;
        if (EXTERNAL_TRIGGER_ENABLE_IN) begin
            host_pulse = HOST_TRIGGER_COMMAND_IN &&
                         origin_ff == ORIGIN_HOST;
            if (origin_ff == ORIGIN_LINE1) begin
                ext_pulse = line_pulse[0];
            end else if (origin_ff == ORIGIN_LINE2) begin
                ext_pulse = line_pulse[1];
            end
        end
    end

    // Limited rate is the slower of programmed and maximum.
    always_comb begin
        period = MIN_FRAME_PERIOD_IN;
        if (INTERNAL_RATE_LIMIT_ENABLE_IN &&
            PROGRAMMED_PERIOD_IN > MIN_FRAME_PERIOD_IN) begin
            period = PROGRAMMED_PERIOD_IN;
        end
    end

    // Stop wins over begin in the same cycle, so a host that aborts at once
    // never sees a stray frame unless an acquisition was already active.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            acq_active_ff <= 1'b0;
        end else if (END_ACQUISITION_COMMAND_IN) begin
            acq_active_ff <= 1'b0;
        end else if (BEGIN_ACQUISITION_COMMAND_IN) begin
            acq_active_ff <= 1'b1;
        end else if (int_pulse && !CONTINUOUS_MODE_IN) begin
            acq_active_ff <= 1'b0;
        end
    end

    // The rate counter stops at the period, so the first internal trigger waits
    // one full period after a frame; only a begin while active fires it sooner.
    // Restarting at one counts the trigger cycle itself, so internal starts
    // are exactly one period apart rather than one cycle more.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rate_cnt_ff <= CNT_ZERO;
        end else if (trig) begin
            rate_cnt_ff <= CNT_ONE;
        end else if (rate_cnt_ff < period) begin
            rate_cnt_ff <= rate_cnt_ff + CNT_ONE;
        end
    end

    assign int_pulse = !EXTERNAL_TRIGGER_ENABLE_IN && acq_active_ff &&
                       state_ff == ST_WAIT &&
                       (rate_cnt_ff >= period || BEGIN_ACQUISITION_COMMAND_IN);
    assign waiting   = state_ff == ST_WAIT;
    assign trig      = waiting && (host_pulse || ext_pulse || int_pulse);

    // The idle state lasts one cycle after reset only, so nothing can start
    // a frame while the configuration inputs are still settling.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (trig) begin
                    nxt_state = ST_EXPOSE;
                end
            end
            ST_EXPOSE: begin
                if (expo_cnt_ff <= CNT_ONE) begin
                    nxt_state = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (PIPELINE_READY_IN) begin
                    nxt_state = ST_WAIT;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Exposure length from the duration setting; the width mode has no
    // line-driven end, so the same count ends its exposure too.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            expo_cnt_ff <= CNT_ZERO;
        end else if (trig) begin
            expo_cnt_ff <= EXPOSURE_DURATION_SETTING_IN;
        end else if (expo_cnt_ff != CNT_ZERO) begin
            expo_cnt_ff <= expo_cnt_ff - CNT_ONE;
        end
    end

    // Waiting and exposing levels come from the next state so that they line up with the
    // state register instead of trailing it by a cycle.
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FRAME_START_OUT     <= 1'b0;
            OVERTRIGGER_OUT     <= 1'b0;
            IGNORED_TRIGGER_OUT <= 1'b0;
            WAITING_OUT         <= 1'b0;
            EXPOSING_OUT        <= 1'b0;
            TRIGGER_ORIGIN_OUT  <= ORIGIN_RESET;
        end else begin
            FRAME_START_OUT     <= trig;
            // Dropped outright: nothing is remembered for later.
            IGNORED_TRIGGER_OUT <= !waiting &&
                                   (host_pulse || ext_pulse);
            OVERTRIGGER_OUT     <= state_ff == ST_EXPOSE &&
                                   EXPOSURE_CONTROL_SELECT_IN == EXPO_TIMED &&
                                   (host_pulse || ext_pulse);
            WAITING_OUT         <= nxt_state == ST_WAIT;
            EXPOSING_OUT        <= nxt_state == ST_EXPOSE;
            TRIGGER_ORIGIN_OUT  <= origin_ff;
        end
    end

endmodule

// [design/ast_pkg.sv]
package ast_pkg;

    // Trigger origin encodings.
    localparam logic [1:0] ORIGIN_HOST   = 2'h0;
    localparam logic [1:0] ORIGIN_LINE1  = 2'h1;
    localparam logic [1:0] ORIGIN_LINE2  = 2'h2;
    localparam logic [1:0] ORIGIN_RESET  = ORIGIN_LINE1;

    // Edge select and exposure control encodings.
    localparam logic       EDGE_RISING   = 1'h0;
    localparam logic       EDGE_FALLING  = 1'h1;
    localparam logic       EXPO_TIMED    = 1'h0;
    localparam logic       EXPO_WIDTH    = 1'h1;

    // Counter width, line count and counter constants.
    localparam int         CNT_W         = 32;
    localparam int         LINE_COUNT    = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 32'h1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_EXPOSE,
        ST_RECOVER
    } ast_state_t;

endpackage

// [design/ast_edge_detect.sv]
`timescale 1ns/1ps

module ast_edge_detect
    import ast_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic level_in,
    input  wire logic falling_in,
    output logic      pulse_out
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // Two-stage synchroniser; the second stage and its delayed copy feed the edge compare.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= level_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pulse_out <= 1'b0;
        end else if (falling_in == EDGE_FALLING) begin
            pulse_out <= prev_ff & ~sync2_ff;
        end else begin
            pulse_out <= ~prev_ff & sync2_ff;
        end
    end

endmodule

// [tb/ast_trigger_asserts.sv]
`timescale 1ns/1ps
module ast_trigger_asserts
    import ast_pkg::*;
(
    // Clock and reset
    input wire logic       CLK_IN,
    input wire logic       RST_IN,
    // Inputs
    input wire logic       EXTERNAL_TRIGGER_ENABLE_IN,
    input wire logic       TRIGGER_EDGE_SELECT_IN,
    input wire logic       HOST_TRIGGER_COMMAND_IN,
    input wire logic [1:0] EXTERNAL_START_TRIGGER_INPUT_IN,
    input wire logic       PIPELINE_READY_IN,
    // Outputs
    input wire logic [1:0] TRIGGER_ORIGIN_OUT,
    input wire logic       WAITING_OUT,
    input wire logic       EXPOSING_OUT,
    input wire logic       FRAME_START_OUT,
    input wire logic       OVERTRIGGER_OUT,
    input wire logic       IGNORED_TRIGGER_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    wire logic       ext = EXTERNAL_TRIGGER_ENABLE_IN;
    wire logic [1:0] org = TRIGGER_ORIGIN_OUT;
    property p_host; ext && org == ORIGIN_HOST && WAITING_OUT &&
        HOST_TRIGGER_COMMAND_IN |=> FRAME_START_OUT; endproperty
    a_host: assert property (p_host) else $error("host start lost");
    property p_leave; FRAME_START_OUT |-> !WAITING_OUT; endproperty
    a_leave: assert property (p_leave) else $error("still waiting");
    property p_rearm; ext && PIPELINE_READY_IN && !EXPOSING_OUT &&
        !WAITING_OUT |-> ##[1:3] WAITING_OUT; endproperty
    a_rearm: assert property (p_rearm) else $error("no rearm");
    property p_busy; FRAME_START_OUT |-> $past(WAITING_OUT); endproperty
    a_busy: assert property (p_busy) else $error("busy start");
    property p_line; ext && org == ORIGIN_LINE1 && WAITING_OUT &&
        !TRIGGER_EDGE_SELECT_IN && $rose(EXTERNAL_START_TRIGGER_INPUT_IN[0])
        |-> ##[2:6] FRAME_START_OUT; endproperty
    a_line: assert property (p_line) else $error("line start lost");
    property p_pulse; FRAME_START_OUT |=> !FRAME_START_OUT; endproperty
    a_pulse: assert property (p_pulse) else $error("long start");
    property p_over; OVERTRIGGER_OUT |-> $past(EXPOSING_OUT); endproperty
    a_over: assert property (p_over) else $error("stray overtrigger");
    property p_origin; $fell(RST_IN) |-> org == ORIGIN_LINE1; endproperty
    a_origin: assert property (p_origin) else $error("bad origin");
    property p_ignored; IGNORED_TRIGGER_OUT |-> !$past(WAITING_OUT);
    endproperty
    a_ignored: assert property (p_ignored) else $error("bad drop");
endmodule
bind ast_trigger ast_trigger_asserts i_ast_trigger_asserts (.*);

// [tb/ast_partner.sv]
`timescale 1ns/1ps
module ast_partner (
    // Clock
    input  wire logic  clk_in,
    // Host command and trigger lines
    output logic       host_out,
    output logic [1:0] line_out
);
    initial {host_out, line_out} = 3'h0;
    // Callers space commands a frame apart unless overtrigger is meant.
    task automatic host_cmd();
        @(posedge clk_in) #1 host_out = 1'b1;
        @(posedge clk_in) #1 host_out = 1'b0;
    endtask
    // A level lasts a full cycle so the synchroniser cannot miss it.
    task automatic set_line(input int idx, input logic v);
        @(posedge clk_in) #1 line_out[idx] = v;
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import ast_pkg::*;
;
    logic        CLK_IN = 1'b0, RST_IN = 1'b1, ORIGIN_WRITE_IN = 1'b0;
    logic        EXTERNAL_TRIGGER_ENABLE_IN = 1'b1, CONTINUOUS_MODE_IN = 1'b0;
    logic        TRIGGER_EDGE_SELECT_IN = 1'b0, PIPELINE_READY_IN = 1'b0;
    logic        EXPOSURE_CONTROL_SELECT_IN = EXPO_TIMED;
    logic        INTERNAL_RATE_LIMIT_ENABLE_IN = 1'b0;
    logic        BEGIN_ACQUISITION_COMMAND_IN = 1'b0;
    logic        END_ACQUISITION_COMMAND_IN = 1'b0;
    logic [1:0]  TRIGGER_ORIGIN_SELECT_IN = 2'h0;
    logic [31:0] EXPOSURE_DURATION_SETTING_IN = 32'h4;
    logic [31:0] MIN_FRAME_PERIOD_IN = 32'h14, PROGRAMMED_PERIOD_IN = 32'h28;
    logic        HOST_TRIGGER_COMMAND_IN, WAITING_OUT, EXPOSING_OUT;
    logic        FRAME_START_OUT, OVERTRIGGER_OUT, IGNORED_TRIGGER_OUT;
    logic [1:0]  EXTERNAL_START_TRIGGER_INPUT_IN, TRIGGER_ORIGIN_OUT;
    logic [31:0] fs_n = 32'h0, run = 32'h0, gap = 32'h0, s;
    logic [31:0] ig_n = 32'h0, ov_n = 32'h0;
    int          fail_count = 0, n_checks = 0;
    always #2.5 CLK_IN = ~CLK_IN;
    ast_trigger i_ast_trigger (.*);
    ast_partner i_ast_partner (
        .clk_in   (CLK_IN),
        .host_out (HOST_TRIGGER_COMMAND_IN),
        .line_out (EXTERNAL_START_TRIGGER_INPUT_IN)
    );
    // Frame starts are counted and the last spacing between them kept.
    always @(posedge CLK_IN) begin
        fs_n <= fs_n + 32'(FRAME_START_OUT === 1'b1);
        run <= (FRAME_START_OUT === 1'b1) ? 32'h1 : run + 32'h1;
        if (FRAME_START_OUT === 1'b1) gap <= run;
        ig_n <= ig_n + 32'(IGNORED_TRIGGER_OUT === 1'b1);
        ov_n <= ov_n + 32'(OVERTRIGGER_OUT === 1'b1);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // One-cycle strobe: 0 loads the origin, 1 begins, 2 ends acquisition.
    task automatic pulse(input int k, input logic [1:0] o);
        ORIGIN_WRITE_IN = (k == 0);
        BEGIN_ACQUISITION_COMMAND_IN = (k == 1);
        END_ACQUISITION_COMMAND_IN = (k == 2);
        TRIGGER_ORIGIN_SELECT_IN = o;
        tick(1);
        {ORIGIN_WRITE_IN, BEGIN_ACQUISITION_COMMAND_IN} = 2'h0;
        END_ACQUISITION_COMMAND_IN = 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        tick(5000);
        fail_count++;
        test_done;
    end
    initial begin
        tick(16);
        RST_IN = 1'b0;
        tick(2);
        chk("origin", 32'(ORIGIN_LINE1), 32'(TRIGGER_ORIGIN_OUT));
        pulse(0, ORIGIN_HOST);
        i_ast_partner.host_cmd();
        // The start pulse stands for one cycle only, so it is looked at now.
        chk("start", 32'h1, 32'(FRAME_START_OUT));
        chk("waiting", 32'h0, 32'(WAITING_OUT));
        // A second command lands mid-exposure and must be dropped.
        i_ast_partner.host_cmd();
        tick(20);
        chk("held", 32'h0, 32'(WAITING_OUT));
        chk("ignored", 32'h1, ig_n);
        chk("overtrigger", 32'h1, ov_n);
        PIPELINE_READY_IN = 1'b1;
        tick(3);
        chk("rearm", 32'h1, 32'(WAITING_OUT));
        chk("starts", 32'h1, fs_n);
        for (int k = 0; k < 4; k++) begin
            pulse(0, k[1] ? ORIGIN_LINE2 : ORIGIN_LINE1);
            TRIGGER_EDGE_SELECT_IN = k[0];
            EXPOSURE_CONTROL_SELECT_IN = (k == 3) ? EXPO_WIDTH : EXPO_TIMED;
            i_ast_partner.set_line(k[1], k[0]);
            tick(10);
            s = fs_n;
            i_ast_partner.set_line(k[1], !k[0]);
            i_ast_partner.set_line(k[1], k[0]);
            i_ast_partner.set_line(k[1], !k[0]);
            // Back to waiting first, so only the origin filter can drop it.
            tick(20);
            i_ast_partner.set_line(!k[1], 1'b1);
            tick(20);
            i_ast_partner.set_line(!k[1], 1'b0);
            i_ast_partner.set_line(k[1], k[0]);
            tick(20);
            chk("line starts", s + 32'h1, fs_n);
        end
        chk("ignored", 32'h5, ig_n);
        chk("overtrigger", 32'h4, ov_n);
        EXPOSURE_CONTROL_SELECT_IN = EXPO_TIMED;
        EXTERNAL_TRIGGER_ENABLE_IN = 1'b0;
        s = fs_n;
        pulse(1, 2'h0);
        tick(100);
        chk("single", s + 32'h1, fs_n);
        CONTINUOUS_MODE_IN = 1'b1;
        for (int j = 0; j < 3; j++) begin
            INTERNAL_RATE_LIMIT_ENABLE_IN = (j > 0);
            PROGRAMMED_PERIOD_IN = (j == 2) ? 32'ha : 32'h28;
            pulse(1, 2'h0);
            tick(100);
            chk("period", (j == 1) ? 32'h28 : 32'h14, gap);
            pulse(2, 2'h0);
            tick(50);
            s = fs_n;
            tick(50);
            chk("stopped", s, fs_n);
        end
        test_done;
    end
endmodule
